// ---- tbcp_ahb_slave.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbcp_ahb_slave (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register file side
  tbcp_reg_if.slave rif
);

  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic take;

  // ==========================================================================
  // Address phase decode; hsize is ignored, only whole words are used
  assign take = hsel && hready && htrans[1];
  assign rif.rd_addr = haddr[7:0];
  assign rif.wr_en = wr_pend_reg;
  assign rif.wr_addr = wr_addr_reg;
  assign rif.wdata = hwdata;

  // Zero wait states and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture a write for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // Read data sampled at the address phase so it stands from a flop in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rif.rdata;
    end
  end

endmodule

`default_nettype wire

// ---- tbcp_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Port-level checks on the parser top
module tbcp_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  // Byte stream and status
  input wire logic mac_valid,
  input wire logic mac_ready,
  input wire logic [7:0] mac_data,
  input wire logic mac_last,
  input wire logic mac_add_crc,
  input wire logic mac_add_pad,
  input wire logic txstat_valid,
  input wire logic [31:0] txstat_word,
  input wire logic transmit_error_flag,
  input wire logic buffer_done_irq_flag
);
  logic wr_a;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Write address phase taken; a sticky flag may only drop two edges later
  assign wr_a = hsel & hwrite & htrans[1];
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  chk_byte_hold: assert property (mac_valid && !mac_ready |=>
    mac_valid && $stable(mac_data) && $stable(mac_last)) else $error("byte dropped early");
  chk_crc_kept: assert property (!mac_add_pad |-> mac_add_crc)
    else $error("check sequence dropped with padding off");
  chk_stat_pulse: assert property (txstat_valid |=> !txstat_valid)
    else $error("status pulse too long");
  chk_stat_zero: assert property (txstat_valid |-> txstat_word[14:0] == 15'h0)
    else $error("status low bits not zero");
  chk_err_flag: assert property (txstat_valid && txstat_word[15] |-> transmit_error_flag)
    else $error("error flag missing");
  chk_err_sticky: assert property ($fell(transmit_error_flag) |-> $past(wr_a, 2))
    else $error("error flag fell without a write");
  chk_done_sticky: assert property ($fell(buffer_done_irq_flag) |-> $past(wr_a, 2))
    else $error("done flag fell without a write");
  // A closing byte ends the frame: no byte of the next packet follows at once
  chk_frame_end: assert property (mac_valid && mac_ready && mac_last |=> !mac_valid)
    else $error("byte offered right after the closing byte");
  cover property (txstat_valid && txstat_word[15]);
  cover property (mac_valid && mac_ready && mac_last);
  cover property (mac_valid && !mac_add_pad);
endmodule

bind tbcp_top tbcp_chk i_tbcp_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hreadyout,
  .hresp, .mac_valid, .mac_ready, .mac_data, .mac_last, .mac_add_crc, .mac_add_pad,
  .txstat_valid, .txstat_word, .transmit_error_flag, .buffer_done_irq_flag);

`default_nettype wire

// ---- tbcp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Host side feeding the transmit data FIFO
module tbcp_host_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pace control
  input wire logic slow,
  // FIFO write side
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [31:0] fifo_data
);
  logic [31:0] q[$];
  // Hold a word until taken; idle data flips so a stale word never passes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_valid <= 1'b0;
      fifo_data <= 32'h0;
    end else if (fifo_valid && !fifo_ready) begin
      fifo_valid <= 1'b1;
    end else if (q.size() > 0 && !(slow && $urandom % 2 == 0)) begin
      fifo_valid <= 1'b1;
      fifo_data <= q.pop_front();
    end else begin
      fifo_valid <= 1'b0;
      fifo_data <= ~fifo_data;
    end
  end
endmodule

`default_nettype wire

// ---- tbcp_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Register access from the bus slave to the register file
interface tbcp_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wdata;
  logic [7:0] rd_addr;
  logic [31:0] rdata;
  modport slave (output wr_en, output wr_addr, output wdata, output rd_addr, input rdata);
  modport regs (input wr_en, input wr_addr, input wdata, input rd_addr, output rdata);
endinterface

// ============================================================================
// One data word with its valid byte lanes, handed to the byte unpacker
interface tbcp_lane_if;
  logic valid;
  logic ready;
  logic [31:0] word;
  logic [1:0] lane;
  logic [2:0] nbytes;
  logic last;
  modport src (output valid, input ready, output word, output lane, output nbytes,
               output last);
  modport dst (input valid, output ready, input word, input lane, input nbytes,
               input last);
endinterface

`default_nettype wire

// ---- tbcp_pkg.sv ----
package tbcp_pkg;

  // ==========================================================================
  // First command word layout
  localparam int unsigned CMDA_IOC_BIT = 31;
  localparam int unsigned CMDA_ALIGN_LSB = 24;
  localparam int unsigned CMDA_OFS_LSB = 16;
  localparam int unsigned CMDA_FIRST_BIT = 13;
  localparam int unsigned CMDA_LAST_BIT = 12;
  localparam int unsigned CMD_SIZE_LSB = 0;

  // ==========================================================================
  // Second command word layout
  localparam int unsigned CMDB_TAG_LSB = 16;
  localparam int unsigned CMDB_CRC_DIS_BIT = 13;
  localparam int unsigned CMDB_PAD_DIS_BIT = 12;

  // ==========================================================================
  // End alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // Short frames are padded up to this length by the MAC
  localparam logic [6:0] MIN_FRAME_BYTES = 7'h40;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TXSTAT_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0C;

  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned STAT_TXERR_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned TXSTAT_ERR_BIT = 15;

  // Reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [31:0] TXSTAT_RST = 32'h0000_0000;

  // ==========================================================================
  // Parser states
  typedef enum logic [5:0] {
    ST_CMDA = 6'h01,
    ST_CMDB = 6'h02,
    ST_OFS = 6'h04,
    ST_DATA = 6'h08,
    ST_PAD = 6'h10,
    ST_DONE = 6'h20
  } tbcp_state_t;

endpackage

// ---- tbcp_top.sv ----
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Bit 13 of the first command word opens a new packet.
// - Bit 12 of the first command word closes the packet after this buffer.
// - Bits 10:0 of the first command word give payload bytes, no offset or padding.
// - Offset, byte count and end alignment give the padding words, which are discarded.
// - Buffer sizes summed over a packet; mismatch with packet length sets error.
// - Tag in bits 31:16 of the second word goes into the status word.
// - Bit 13 of the second command word suppresses the appended frame check sequence.
// - Bit 12 of the second command word stops padding frames under 64 bytes.
// - With padding disabled the frame check sequence is always appended.
// - Bits 10:0 of the second word are packet length; mismatch sets error.
// - Data region starts at the word after the command words.
// - Low two offset bits choose the first valid byte lane.
// - Upper offset bits give up to seven whole words skipped before data.
// - Unused trailing bytes of the last data word are not passed on.
// - End filler for 4, 16 or 32 byte alignment is removed.
// - Bits 25:24 of the first word: 4, 16, 32 byte alignment, 11 reserved.
// - Bit 31 of the first word sets the buffer-done flag once the whole buffer has been read.
// - Only buffers with the opening flag carry the second command word.

module tbcp_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Transmit data FIFO words
  input wire logic fifo_valid,
  output logic fifo_ready,
  input wire logic [31:0] fifo_data,
  // MAC transmit byte stream
  output logic mac_valid,
  input wire logic mac_ready,
  output logic [7:0] mac_data,
  output logic mac_last,
  // Per-packet frame controls
  output logic mac_add_crc,
  output logic mac_add_pad,
  // Transmit status word
  output logic txstat_valid,
  output logic [31:0] txstat_word,
  // Flags
  output logic transmit_error_flag,
  output logic buffer_done_irq_flag
);

  tbcp_reg_if rif ();
  tbcp_lane_if lif ();

  tbcp_pkg::tbcp_state_t state_reg;
  logic en_reg;
  logic ioc_reg;
  logic last_seg_reg;
  logic [1:0] align_reg;
  logic [4:0] ofs_reg;
  logic [10:0] size_reg;
  logic [15:0] tag_reg;
  logic crc_dis_reg;
  logic pad_dis_reg;
  logic [10:0] pkt_len_reg;
  logic [15:0] sum_reg;
  logic in_pkt_reg;
  logic [2:0] ofs_left_reg;
  logic [10:0] bytes_left_reg;
  logic first_word_reg;
  logic [2:0] pad_left_reg;
  logic take;
  logic err_set;
  logic done_set;
  logic err_clr;
  logic done_clr;
  logic [1:0] lane_now;
  logic [2:0] room;

  // ==========================================================================
  // Helpers
  // Payload words spanned by a byte count starting at a lane
  function automatic logic [9:0] data_words(input logic [1:0] lane, input logic [10:0] n);
    logic [11:0] t;
    t = {10'h000, lane} + {1'b0, n} + 12'h003;
    return t[11:2];
  endfunction

  // Filler words needed to round the region up to the alignment
  function automatic logic [2:0] pad_words(input logic [1:0] al, input logic [9:0] words);
    logic [2:0] mask;
    mask = 3'h0;
    case (al)
      tbcp_pkg::ALIGN_16: mask = 3'h3;
      tbcp_pkg::ALIGN_32: mask = 3'h7;
      default: mask = 3'h0; // Reserved code handled as 4-byte
    endcase
    return (3'h0 - words[2:0]) & mask;
  endfunction

  // ==========================================================================
  // Sub-blocks
  tbcp_ahb_slave u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rif(rif)
  );

  tbcp_unpack u_unpack (
    .hclk(hclk),
    .hresetn(hresetn),
    .lif(lif),
    .mac_valid(mac_valid),
    .mac_ready(mac_ready),
    .mac_data(mac_data),
    .mac_last(mac_last)
  );

  // ==========================================================================
  // FIFO handshake; the unpacker's back-pressure stalls data words
  always_comb begin
    case (state_reg)
      tbcp_pkg::ST_CMDA: fifo_ready = en_reg;
      tbcp_pkg::ST_CMDB: fifo_ready = !mac_valid; // Old bytes leave before controls change
      tbcp_pkg::ST_OFS: fifo_ready = (ofs_left_reg != 3'h0);
      tbcp_pkg::ST_PAD: fifo_ready = (pad_left_reg != 3'h0);
      tbcp_pkg::ST_DATA: fifo_ready = lif.ready;
      default: fifo_ready = 1'b0;
    endcase
  end
  assign take = fifo_valid && fifo_ready;

  // Lane and byte count for the current data word
  assign lane_now = first_word_reg ? ofs_reg[1:0] : 2'h0;
  assign room = 3'h4 - {1'b0, lane_now};
  assign lif.valid = (state_reg == tbcp_pkg::ST_DATA) && fifo_valid;
  assign lif.word = fifo_data;
  assign lif.lane = lane_now;
  assign lif.nbytes = (bytes_left_reg < {8'h00, room}) ? bytes_left_reg[2:0] : room;
  assign lif.last = last_seg_reg && (bytes_left_reg <= {8'h00, room});

  // ==========================================================================
  // Parser state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= tbcp_pkg::ST_CMDA;
    end else begin
      case (state_reg)
        tbcp_pkg::ST_CMDA: begin
          if (take) begin
            // Second word follows only on an opening buffer
            state_reg <= fifo_data[tbcp_pkg::CMDA_FIRST_BIT] ? tbcp_pkg::ST_CMDB
                                                           : tbcp_pkg::ST_OFS;
          end
        end
        tbcp_pkg::ST_CMDB: begin
          if (take) begin
            state_reg <= tbcp_pkg::ST_OFS;
          end
        end
        tbcp_pkg::ST_OFS: begin
          if (ofs_left_reg == 3'h0 || (take && ofs_left_reg == 3'h1)) begin
            state_reg <= (size_reg != 11'h000) ? tbcp_pkg::ST_DATA : tbcp_pkg::ST_PAD;
          end
        end
        tbcp_pkg::ST_DATA: begin
          if (take && bytes_left_reg <= {8'h00, room}) begin
            state_reg <= tbcp_pkg::ST_PAD;
          end
        end
        tbcp_pkg::ST_PAD: begin
          if (pad_left_reg == 3'h0 || (take && pad_left_reg == 3'h1)) begin
            state_reg <= tbcp_pkg::ST_DONE;
          end
        end
        tbcp_pkg::ST_DONE: state_reg <= tbcp_pkg::ST_CMDA;
        default: state_reg <= tbcp_pkg::ST_CMDA;
      endcase
    end
  end

  // Command field capture; reserved bits are never looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ioc_reg <= 1'b0;
      last_seg_reg <= 1'b0;
      align_reg <= tbcp_pkg::ALIGN_4;
      ofs_reg <= 5'h00;
      size_reg <= 11'h000;
      tag_reg <= 16'h0000;
      crc_dis_reg <= 1'b0;
      pad_dis_reg <= 1'b0;
      pkt_len_reg <= 11'h000;
    end else if (take && state_reg == tbcp_pkg::ST_CMDA) begin
      ioc_reg <= fifo_data[tbcp_pkg::CMDA_IOC_BIT];
      last_seg_reg <= fifo_data[tbcp_pkg::CMDA_LAST_BIT];
      align_reg <= fifo_data[tbcp_pkg::CMDA_ALIGN_LSB +: 2];
      ofs_reg <= fifo_data[tbcp_pkg::CMDA_OFS_LSB +: 5];
      size_reg <= fifo_data[tbcp_pkg::CMD_SIZE_LSB +: 11];
    end else if (take && state_reg == tbcp_pkg::ST_CMDB) begin
      tag_reg <= fifo_data[tbcp_pkg::CMDB_TAG_LSB +: 16];
      crc_dis_reg <= fifo_data[tbcp_pkg::CMDB_CRC_DIS_BIT];
      pad_dis_reg <= fifo_data[tbcp_pkg::CMDB_PAD_DIS_BIT];
      pkt_len_reg <= fifo_data[tbcp_pkg::CMD_SIZE_LSB +: 11];
    end
  end

  // Word counters for offset and filler, byte counter for payload
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ofs_left_reg <= 3'h0;
      bytes_left_reg <= 11'h000;
      first_word_reg <= 1'b0;
      pad_left_reg <= 3'h0;
    end else begin
      if (state_reg == tbcp_pkg::ST_CMDA && take) begin
        ofs_left_reg <= fifo_data[tbcp_pkg::CMDA_OFS_LSB + 2 +: 3];
        bytes_left_reg <= fifo_data[tbcp_pkg::CMD_SIZE_LSB +: 11];
        first_word_reg <= 1'b1;
        // Filler counted over offset words plus payload words
        pad_left_reg <= pad_words(fifo_data[tbcp_pkg::CMDA_ALIGN_LSB +: 2],
          data_words(fifo_data[tbcp_pkg::CMDA_OFS_LSB +: 2],
                     fifo_data[tbcp_pkg::CMD_SIZE_LSB +: 11])
          + {7'h00, fifo_data[tbcp_pkg::CMDA_OFS_LSB + 2 +: 3]});
      end
      if (state_reg == tbcp_pkg::ST_OFS && take && ofs_left_reg != 3'h0) begin
        ofs_left_reg <= ofs_left_reg - 3'h1;
      end
      if (state_reg == tbcp_pkg::ST_DATA && take) begin
        bytes_left_reg <= bytes_left_reg - {8'h00, lif.nbytes};
        first_word_reg <= 1'b0;
      end
      if (state_reg == tbcp_pkg::ST_PAD && take && pad_left_reg != 3'h0) begin
        pad_left_reg <= pad_left_reg - 3'h1;
      end
    end
  end

  // Packet accumulation; an opening buffer restarts the sum
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_reg <= 16'h0000;
      in_pkt_reg <= 1'b0;
    end else if (take && state_reg == tbcp_pkg::ST_CMDA) begin
      if (fifo_data[tbcp_pkg::CMDA_FIRST_BIT]) begin
        sum_reg <= {5'h00, fifo_data[tbcp_pkg::CMD_SIZE_LSB +: 11]};
      end else begin
        sum_reg <= sum_reg + {5'h00, fifo_data[tbcp_pkg::CMD_SIZE_LSB +: 11]};
      end
      in_pkt_reg <= !fifo_data[tbcp_pkg::CMDA_LAST_BIT];
    end
  end

  // ==========================================================================
  // Buffer end: length check and status word
  assign err_set = (state_reg == tbcp_pkg::ST_DONE) && last_seg_reg
                   && (sum_reg != {5'h00, pkt_len_reg});
  assign done_set = (state_reg == tbcp_pkg::ST_DONE) && ioc_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txstat_valid <= 1'b0;
      txstat_word <= tbcp_pkg::TXSTAT_RST;
    end else begin
      txstat_valid <= (state_reg == tbcp_pkg::ST_DONE) && last_seg_reg;
      if (state_reg == tbcp_pkg::ST_DONE && last_seg_reg) begin
        txstat_word <= {tag_reg, err_set, 15'h0000};
      end
    end
  end

  // Frame controls held for the packet; padding off forces the check sequence
  assign mac_add_crc = !crc_dis_reg || pad_dis_reg;
  assign mac_add_pad = !pad_dis_reg;

  // ==========================================================================
  // Registers; sticky flags clear on write-one, a same-cycle set wins
  assign err_clr = rif.wr_en && rif.wr_addr == tbcp_pkg::STAT_OFS
                   && rif.wdata[tbcp_pkg::STAT_TXERR_BIT];
  assign done_clr = rif.wr_en && rif.wr_addr == tbcp_pkg::STAT_OFS
                    && rif.wdata[tbcp_pkg::STAT_DONE_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg <= tbcp_pkg::CTRL_EN_RST;
    end else if (rif.wr_en && rif.wr_addr == tbcp_pkg::CTRL_OFS) begin
      en_reg <= rif.wdata[tbcp_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_error_flag <= 1'b0;
      buffer_done_irq_flag <= 1'b0;
    end else begin
      transmit_error_flag <= err_set || (transmit_error_flag && !err_clr);
      buffer_done_irq_flag <= done_set || (buffer_done_irq_flag && !done_clr);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rif.rdata = 32'h0000_0000;
    case (rif.rd_addr)
      tbcp_pkg::CTRL_OFS: rif.rdata[tbcp_pkg::CTRL_EN_BIT] = en_reg;
      tbcp_pkg::STAT_OFS: begin
        rif.rdata[tbcp_pkg::STAT_TXERR_BIT] = transmit_error_flag;
        rif.rdata[tbcp_pkg::STAT_DONE_BIT] = buffer_done_irq_flag;
        rif.rdata[tbcp_pkg::STAT_BUSY_BIT] = in_pkt_reg || (state_reg != tbcp_pkg::ST_CMDA);
      end
      tbcp_pkg::TXSTAT_OFS: rif.rdata = txstat_word;
      tbcp_pkg::COUNT_OFS: rif.rdata = {16'h0000, sum_reg};
      default: rif.rdata = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

// ---- tbcp_unpack.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbcp_unpack (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Words from the parser
  tbcp_lane_if.dst lif,
  // Byte stream to the MAC transmit path
  output logic mac_valid,
  input wire logic mac_ready,
  output logic [7:0] mac_data,
  output logic mac_last
);

  logic [31:0] word_reg;
  logic [1:0] lane_reg;
  logic [2:0] left_reg;
  logic last_reg;
  logic pop;

  // ==========================================================================
  // Accept a new word when empty or when the final byte is leaving
  assign pop = mac_ready && (left_reg == 3'h1);
  assign lif.ready = (left_reg == 3'h0) || pop;
  assign mac_valid = (left_reg != 3'h0);
  assign mac_data = word_reg[{lane_reg, 3'h0} +: 8];
  assign mac_last = last_reg && (left_reg == 3'h1);

  // Walk the lanes low to high; bytes past the count are never offered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_reg <= 32'h0000_0000;
      lane_reg <= 2'h0;
      left_reg <= 3'h0;
      last_reg <= 1'b0;
    end else if (lif.valid && lif.ready) begin
      word_reg <= lif.word;
      lane_reg <= lif.lane;
      left_reg <= lif.nbytes;
      last_reg <= lif.last;
    end else if (mac_valid && mac_ready) begin
      lane_reg <= lane_reg + 2'h1;
      left_reg <= left_reg - 3'h1;
    end
  end

endmodule

`default_nettype wire

// ---- test_tx_buffer_command_parser.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_tx_buffer_command_parser;
  logic hclk, hresetn, hsel, hwrite, mac_ready, slow, hreadyout, hresp, fifo_valid;
  logic fifo_ready, mac_valid, mac_last, mac_add_crc, mac_add_pad, txstat_valid;
  logic transmit_error_flag, buffer_done_irq_flag;
  logic [31:0] haddr, hwdata, hrdata, fifo_data, txstat_word, rd, b;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] mac_data;
  logic [10:0] ex_q[$];
  logic [31:0] st_q[$];
  int err_total, tests_run, sum, n;

  // ==========================================================================
  // Design, host model and clock
  tbcp_top i_tbcp_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fifo_valid, .fifo_ready, .fifo_data,
    .mac_valid, .mac_ready, .mac_data, .mac_last, .mac_add_crc, .mac_add_pad,
    .txstat_valid, .txstat_word, .transmit_error_flag, .buffer_done_irq_flag);
  tbcp_host_model i_tbcp_host_model (.hclk, .hresetn, .slow, .fifo_valid, .fifo_ready,
    .fifo_data);
  always #5 hclk = ~hclk;

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic push(input logic [31:0] w);
    i_tbcp_host_model.q.push_back(w);
  endtask

  // One buffer as the host lays it out, with the bytes the MAC should see
  task automatic buf_tx(input bit fs, input bit ls, input int n, input int ofs, input int al);
    int lane, nw, fill, i;
    logic [31:0] w;
    logic [7:0] bt;
    lane = ofs % 4;
    nw = (lane + n + 3) / 4;
    fill = al == 1 ? 4 : al == 2 ? 8 : 1;
    fill = (fill - (ofs / 4 + nw) % fill) % fill;
    if (fs) sum = 0;
    sum += n;
    push({ls, 5'h0, 2'(al), 3'h0, 5'(ofs), 2'h0, fs, ls, 1'b0, 11'(n)});
    if (fs) push(b);
    repeat (ofs / 4) push($urandom);
    for (i = 0; i < nw * 4; i++) begin
      bt = 8'($urandom);
      w[8 * (i % 4) +: 8] = bt;
      if (i >= lane && i < lane + n) ex_q.push_back({!b[13] | b[12], !b[12],
        ls && i == lane + n - 1, bt});
      if (i % 4 == 3) push(w);
    end
    repeat (fill) push($urandom);
    if (ls) st_q.push_back({b[31:16], 1'(sum != int'(b[10:0])), 15'h0});
  endtask

  task automatic drain;
    int k;
    k = 0;
    while ((ex_q.size() + st_q.size() + i_tbcp_host_model.q.size()) > 0 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    chk("drained", 32'h0, 32'(ex_q.size() + st_q.size()));
    repeat (4) @(posedge hclk);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Model compare at every byte and status word; MAC stalls at random
  always @(posedge hclk) begin
    mac_ready <= ($urandom % 4) != 0;
    slow <= ($urandom % 8) == 0;
    if (hresetn && mac_valid && mac_ready)
      chk("mac byte", 32'(ex_q.pop_front()),
        {21'h0, mac_add_crc, mac_add_pad, mac_last, mac_data});
    if (hresetn && txstat_valid) chk("status word", st_q.pop_front(), txstat_word);
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    hclk = 0;
    hresetn = 0;
    {hsel, hwrite, htrans, haddr, hwdata, err_total, tests_run} = '0;
    hsize = 3'h2;
    void'($urandom(32'hBAF93CAC));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1, 8'h10, 32'hFFFFFFFF);
    ahb(0, 8'h10, 0);
    chk("unmapped", 32'h0, rd);
    ahb(0, tbcp_pkg::CTRL_OFS, 0);
    chk("ctrl", 32'h1, rd);
    ahb(0, tbcp_pkg::STAT_OFS, 0);
    chk("stat", 32'h0, rd);
    $display("test registers done");
    // Every alignment, every first lane, every check-sequence and pad combination
    for (int al = 0; al < 4; al++) begin
      for (int lo = 0; lo < 4; lo++) begin
        n = 1 + $urandom % 70;
        b = {16'(al * 4 + lo), 2'h0, 2'(lo), 1'b0, 11'(n)};
        buf_tx(1, 1, n, lo + 4 * ($urandom % 8), al);
      end
      drain();
    end
    $display("test alignment done");
    // Three segments, first with the right total then one short
    for (int e = 0; e < 2; e++) begin
      b = {16'h0A51, 5'h0, 11'(9 - e)};
      buf_tx(1, 0, 3, 3, 1);
      buf_tx(0, 0, 4, 0, 2);
      buf_tx(0, 1, 2, 5, 0);
      drain();
    end
    ahb(0, tbcp_pkg::STAT_OFS, 0);
    chk("stat flags", 32'h3, rd & 32'h3);
    chk("flag pins", 32'h3, {30'h0, buffer_done_irq_flag, transmit_error_flag});
    ahb(0, tbcp_pkg::TXSTAT_OFS, 0);
    chk("last status", 32'h0A518000, rd);
    ahb(1, tbcp_pkg::STAT_OFS, 32'h3);
    ahb(0, tbcp_pkg::STAT_OFS, 0);
    chk("stat cleared", 32'h0, rd & 32'h3);
    $display("test segments done");
    // Disabled parser leaves the command word waiting
    ahb(1, tbcp_pkg::CTRL_OFS, 0);
    b = {16'h0077, 5'h0, 11'd6};
    buf_tx(1, 1, 6, 2, 0);
    repeat (12) @(posedge hclk);
    chk("held", 32'h1, {31'h0, fifo_valid});
    ahb(1, tbcp_pkg::CTRL_OFS, 32'h1);
    drain();
    $display("test enable done");
    wrap_up;
  end
endmodule

`default_nettype wire
